// ---- verilog/clock_select_defs.vh ----
// Constants for clock source selection, start-up timing and trim registers
`ifndef CLOCK_SELECT_DEFS_VH
`define CLOCK_SELECT_DEFS_VH

// Source select codes
`define SRC_EXTERNAL      4'h0
`define SRC_RC_8M         4'h2
`define SRC_LF_128K       4'h3

// Start-up time codes
`define SUT_NO_DELAY      2'h0
`define SUT_FAST_RISE     2'h1
`define SUT_SLOW_RISE     2'h2

// System clock rate and added post-reset delays in microseconds
`define MCLK_KHZ          25000
`define KHZ_PER_MHZ       1000
`define RC_FAST_US        4100
`define RC_SLOW_US        65000
`define LF_FAST_US        4000
`define LF_SLOW_US        64000
`define DLY_W             21

// Source clock counts
`define RESET_CK_LAST     5'h0D
`define WAKE_CK_LAST      5'h05

// Oscillator model: phase step per system clock, 16-bit accumulator
`define NCO_RC_BASE       16'h4000
`define NCO_RANGE_STEP    16'h1000
`define NCO_FINE_SHIFT    6
`define NCO_LF_STEP       16'h0150

// Register byte addresses
`define ADDR_TRIM         4'h0
`define ADDR_PRESCALE     4'h4
`define ADDR_STATUS       4'h8

// Prescaler register and trim default
`define PRESC_UNLOCK      8'h80
`define PRESC_WINDOW      3'h4
`define PRESC_DIV1        4'h0
`define PRESC_DIV8        4'h3
`define PRESC_MAX         4'h8
`define TRIM_DEFAULT      8'h87

`endif

// ---- verilog/clock_source_select_startup.v ----
// Clock source selection, start-up sequencing, oscillator trim and clock output
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "clock_select_defs.vh"

module clock_source_select_startup #(
  parameter [`DLY_W-1:0] RC_FAST_CYC = (`RC_FAST_US * `MCLK_KHZ + `KHZ_PER_MHZ - 1) / `KHZ_PER_MHZ,
  parameter [`DLY_W-1:0] RC_SLOW_CYC = (`RC_SLOW_US * `MCLK_KHZ + `KHZ_PER_MHZ - 1) / `KHZ_PER_MHZ,
  parameter [`DLY_W-1:0] LF_FAST_CYC = (`LF_FAST_US * `MCLK_KHZ + `KHZ_PER_MHZ - 1) / `KHZ_PER_MHZ,
  parameter [`DLY_W-1:0] LF_SLOW_CYC = (`LF_SLOW_US * `MCLK_KHZ + `KHZ_PER_MHZ - 1) / `KHZ_PER_MHZ
) (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        reset_in,
  // Non-volatile option bits
  input  wire [3:0]  clock_source_select_bits_in,
  input  wire [1:0]  startup_time_bits_in,
  input  wire        divide_by_eight_option_in,
  input  wire        reset_pin_disable_option_in,
  input  wire        clock_output_option_in,
  input  wire [7:0]  factory_trim_in,
  // External clock and power-down request
  input  wire        external_clock_in,
  input  wire        power_down_in,
  // Normal port function of the clock output pin
  input  wire        port_data_in,
  input  wire        port_oe_in,
  // Avalon-MM slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // System clock, reset, watchdog tick and oscillator trim
  output wire        sys_clk_en_out,
  output wire        sys_reset_out,
  output wire        watchdog_tick_out,
  output wire [7:0]  oscillator_trim_out,
  // Clock output pin
  output wire        clock_output_pin_out,
  output wire        clock_output_pin_oe_out
);

  localparam [4:0] ST_PRE   = 5'h01;
  localparam [4:0] ST_DELAY = 5'h02;
  localparam [4:0] ST_RUN   = 5'h04;
  localparam [4:0] ST_SLEEP = 5'h08;
  localparam [4:0] ST_WAKE  = 5'h10;

  // Two-stage synchronisers for the option, trim, external clock and power-down inputs
  reg [20:0] meta_ff;
  reg [20:0] sync_ff;
  reg        ext_prev_ff;

  wire [3:0] src_sync    = sync_ff[3:0];
  wire [1:0] sut_sync    = sync_ff[5:4];
  wire       div8_sync   = sync_ff[6];
  wire       rstdis_sync = sync_ff[7];
  wire       clock_output_option_sync  = sync_ff[8];
  wire [7:0] trim_sync   = sync_ff[16:9];
  wire       ext_sync    = sync_ff[17];
  wire       pd_sync     = sync_ff[18];

  // Option bits captured at reset
  reg [3:0]  src_ff;
  reg [1:0]  sut_ff;
  reg        div8_ff;
  reg        rstdis_ff;
  reg        clock_output_option_ff;

  reg [7:0]  oscillator_trim_ff;
  reg [15:0] rc_acc_ff;
  reg        rc_tick_ff;
  reg [15:0] lf_acc_ff;
  reg        lf_tick_ff;
  reg [15:0] wdt_acc_ff;
  reg        wdt_tick_ff;
  reg        ext_tick_ff;

  reg [3:0]  prescale_ff;
  reg        presc_unlock_ff;
  reg [2:0]  presc_window_ff;
  reg [7:0]  presc_cnt_ff;
  reg        sys_tick_ff;
  reg        sys_clk_en_ff;
  reg        clk_level_ff;
  reg        pin_out_ff;
  reg        pin_oe_ff;

  reg [4:0]        state_ff;
  reg [4:0]        ck_cnt_ff;
  reg [`DLY_W-1:0] dly_cnt_ff;
  reg              sys_reset_ff;

  reg        wait_ff;
  reg [31:0] readdata_ff;

  wire [16:0] rc_step;
  wire [16:0] rc_sum;
  wire [16:0] lf_sum;
  wire [16:0] wdt_sum;
  wire        src_tick;
  wire [3:0]  presc_eff;
  wire [8:0]  presc_last;
  reg  [`DLY_W-1:0] dly_target;

  genvar gi;
  generate
    for (gi = 0; gi < 21; gi = gi + 1) begin : g_sync
      wire pin_bit;
      if (gi < 4) begin : g_src
        assign pin_bit = clock_source_select_bits_in[gi];
      end else if (gi < 6) begin : g_sut
        assign pin_bit = startup_time_bits_in[gi-4];
      end else if (gi == 6) begin : g_div8
        assign pin_bit = divide_by_eight_option_in;
      end else if (gi == 7) begin : g_rstdis
        assign pin_bit = reset_pin_disable_option_in;
      end else if (gi == 8) begin : g_clock_output_option
        assign pin_bit = clock_output_option_in;
      end else if (gi < 17) begin : g_trim
        assign pin_bit = factory_trim_in[gi-9];
      end else if (gi == 17) begin : g_ext
        assign pin_bit = external_clock_in;
      end else if (gi == 18) begin : g_pd
        assign pin_bit = power_down_in;
      end else begin : g_spare
        assign pin_bit = 1'b0;
      end
      always @(posedge mclk_in) begin
        meta_ff[gi] <= pin_bit;
        sync_ff[gi] <= meta_ff[gi];
      end
    end
  endgenerate

  // Option capture and trim register
  always @(posedge mclk_in) begin
    if (reset_in) begin
      src_ff             <= src_sync;
      sut_ff             <= sut_sync;
      div8_ff            <= div8_sync;
      rstdis_ff          <= rstdis_sync;
      clock_output_option_ff           <= clock_output_option_sync;
      oscillator_trim_ff <= trim_sync;
    end else if (avs_write_in && !wait_ff && avs_address_in == `ADDR_TRIM) begin
      oscillator_trim_ff <= avs_writedata_in[7:0];
    end
  end

  // Oscillator models as phase accumulators on mclk
  assign rc_step = {1'b0, `NCO_RC_BASE}
                 + (oscillator_trim_ff[7] ? {1'b0, `NCO_RANGE_STEP} : 17'h00000)
                 + ({10'h000, oscillator_trim_ff[6:0]} << `NCO_FINE_SHIFT);
  assign rc_sum  = {1'b0, rc_acc_ff} + rc_step;
  assign lf_sum  = {1'b0, lf_acc_ff} + {1'b0, `NCO_LF_STEP};
  assign wdt_sum = {1'b0, wdt_acc_ff} + {1'b0, `NCO_LF_STEP};

  always @(posedge mclk_in) begin
    if (reset_in) begin
      rc_acc_ff   <= 16'h0000;
      rc_tick_ff  <= 1'b0;
      lf_acc_ff   <= 16'h0000;
      lf_tick_ff  <= 1'b0;
      wdt_acc_ff  <= 16'h0000;
      wdt_tick_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      ext_tick_ff <= 1'b0;
    end else begin
      rc_acc_ff   <= rc_sum[15:0];
      rc_tick_ff  <= rc_sum[16];
      lf_acc_ff   <= lf_sum[15:0];
      lf_tick_ff  <= lf_sum[16];
      wdt_acc_ff  <= wdt_sum[15:0];
      wdt_tick_ff <= wdt_sum[16];
      ext_prev_ff <= ext_sync;
      ext_tick_ff <= ext_sync & ~ext_prev_ff;
    end
  end

  assign src_tick = (src_ff == `SRC_RC_8M)    ? rc_tick_ff :
                    (src_ff == `SRC_LF_128K)  ? lf_tick_ff :
                    (src_ff == `SRC_EXTERNAL) ? ext_tick_ff :
                    1'b0;

  // Added post-reset delay in mclk cycles
  always @* begin
    dly_target = {`DLY_W{1'b0}};
    if (src_ff == `SRC_LF_128K) begin
      if (sut_ff == `SUT_FAST_RISE || (sut_ff == `SUT_NO_DELAY && rstdis_ff)) begin
        dly_target = (sut_ff == `SUT_FAST_RISE) ? LF_FAST_CYC : RC_FAST_CYC;
      end else if (sut_ff != `SUT_NO_DELAY) begin
        dly_target = LF_SLOW_CYC;
      end
    end else begin
      if (sut_ff == `SUT_FAST_RISE || (sut_ff == `SUT_NO_DELAY && rstdis_ff)) begin
        dly_target = RC_FAST_CYC;
      end else if (sut_ff != `SUT_NO_DELAY) begin
        dly_target = RC_SLOW_CYC;
      end
    end
  end

  // Start-up sequencer
  always @(posedge mclk_in) begin
    if (reset_in) begin
      state_ff     <= ST_PRE;
      ck_cnt_ff    <= 5'h00;
      dly_cnt_ff   <= {`DLY_W{1'b0}};
      sys_reset_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_PRE: begin
          if (src_tick) begin
            ck_cnt_ff <= ck_cnt_ff + 5'h01;
            if (ck_cnt_ff == `RESET_CK_LAST) begin
              ck_cnt_ff <= 5'h00;
              if (dly_target == {`DLY_W{1'b0}}) begin
                state_ff     <= ST_RUN;
                sys_reset_ff <= 1'b0;
              end else begin
                state_ff <= ST_DELAY;
              end
            end
          end
        end
        ST_DELAY: begin
          dly_cnt_ff <= dly_cnt_ff + {{(`DLY_W-1){1'b0}}, 1'b1};
          if (dly_cnt_ff == dly_target - {{(`DLY_W-1){1'b0}}, 1'b1}) begin
            state_ff     <= ST_RUN;
            sys_reset_ff <= 1'b0;
          end
        end
        ST_RUN: begin
          if (pd_sync) begin
            state_ff <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!pd_sync) begin
            state_ff  <= ST_WAKE;
            ck_cnt_ff <= 5'h00;
          end
        end
        ST_WAKE: begin
          if (src_tick) begin
            ck_cnt_ff <= ck_cnt_ff + 5'h01;
            if (ck_cnt_ff == `WAKE_CK_LAST) begin
              ck_cnt_ff <= 5'h00;
              state_ff  <= ST_RUN;
            end
          end
        end
        default: begin
          state_ff <= ST_PRE;
        end
      endcase
    end
  end

  // Prescaler select with timed unlock
  always @(posedge mclk_in) begin
    if (reset_in) begin
      prescale_ff     <= div8_sync ? `PRESC_DIV8 : `PRESC_DIV1;
      presc_unlock_ff <= 1'b0;
      presc_window_ff <= 3'h0;
    end else begin
      if (presc_unlock_ff) begin
        presc_window_ff <= presc_window_ff - 3'h1;
        if (presc_window_ff == 3'h1) begin
          presc_unlock_ff <= 1'b0;
        end
      end
      if (avs_write_in && !wait_ff && avs_address_in == `ADDR_PRESCALE) begin
        if (avs_writedata_in[7:0] == `PRESC_UNLOCK) begin
          if (!presc_unlock_ff) begin
            presc_unlock_ff <= 1'b1;
            presc_window_ff <= `PRESC_WINDOW;
          end
        end else if (presc_unlock_ff && !avs_writedata_in[7]) begin
          prescale_ff     <= avs_writedata_in[3:0];
          presc_unlock_ff <= 1'b0;
        end
      end
    end
  end

  assign presc_eff  = (prescale_ff > `PRESC_MAX) ? `PRESC_MAX : prescale_ff;
  assign presc_last = (9'h001 << presc_eff) - 9'h001;

  // Divided system clock, gated by the run state, and driven ungated to the output pin
  always @(posedge mclk_in) begin
    if (reset_in) begin
      presc_cnt_ff  <= 8'h00;
      sys_tick_ff   <= 1'b0;
      sys_clk_en_ff <= 1'b0;
      clk_level_ff  <= 1'b0;
      // Pin keeps its clock function during reset
      pin_out_ff    <= clock_output_option_sync ? clk_level_ff : port_data_in;
      pin_oe_ff     <= clock_output_option_sync | port_oe_in;
    end else begin
      sys_tick_ff <= 1'b0;
      if (src_tick) begin
        if (presc_cnt_ff >= presc_last[7:0]) begin
          presc_cnt_ff <= 8'h00;
          sys_tick_ff  <= 1'b1;
        end else begin
          presc_cnt_ff <= presc_cnt_ff + 8'h01;
        end
      end
      sys_clk_en_ff <= sys_tick_ff & (state_ff == ST_RUN);
      if (sys_tick_ff) begin
        clk_level_ff <= ~clk_level_ff;
      end
      pin_out_ff <= clock_output_option_ff ? clk_level_ff : port_data_in;
      pin_oe_ff  <= clock_output_option_ff | port_oe_in;
    end
  end

  // Avalon-MM slave, one wait cycle per access
  always @(posedge mclk_in) begin
    if (reset_in) begin
      wait_ff     <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else begin
      if ((avs_read_in || avs_write_in) && wait_ff) begin
        wait_ff <= 1'b0;
        if (avs_address_in == `ADDR_TRIM) begin
          readdata_ff <= {24'h000000, oscillator_trim_ff};
        end else if (avs_address_in == `ADDR_PRESCALE) begin
          readdata_ff <= {24'h000000, presc_unlock_ff, 3'h0, prescale_ff};
        end else if (avs_address_in == `ADDR_STATUS) begin
          readdata_ff <= {17'h00000, sys_reset_ff, state_ff, clock_output_option_ff, rstdis_ff,
                          div8_ff, sut_ff, src_ff};
        end else begin
          readdata_ff <= 32'h00000000;
        end
      end else begin
        wait_ff <= 1'b1;
      end
    end
  end

  assign avs_readdata_out        = readdata_ff;
  assign avs_waitrequest_out     = wait_ff;
  assign sys_clk_en_out          = sys_clk_en_ff;
  assign sys_reset_out           = sys_reset_ff;
  assign watchdog_tick_out       = wdt_tick_ff;
  assign oscillator_trim_out     = oscillator_trim_ff;
  assign clock_output_pin_out    = pin_out_ff;
  assign clock_output_pin_oe_out = pin_oe_ff;

endmodule // clock_source_select_startup

// ---- test/clock_source_select_startup_properties.sv ----
// Checker of bus timing, trim register, clock pin and start-up gating
`timescale 1ns/10ps
module clk_sel_checker (
  // Clock, reset and options
  input wire        mclk_in,
  input wire        reset_in,
  input wire        clock_output_option_in,
  input wire [7:0]  factory_trim_in,
  input wire        power_down_in,
  input wire        port_data_in,
  input wire        port_oe_in,
  // Register bus
  input wire [3:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  // Clocks and pin
  input wire        sys_clk_en_out,
  input wire        sys_reset_out,
  input wire [7:0]  oscillator_trim_out,
  input wire        clock_output_pin_out,
  input wire        clock_output_pin_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire rd_done = avs_read_in && !avs_waitrequest_out;
  wire wr_done = avs_write_in && !avs_waitrequest_out;
  sequence one_wait;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  AST_BUS_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> one_wait)
    else $error("bus answer not after one wait cycle");
  AST_TRIM_LOAD: assert property ($fell(reset_in) |-> oscillator_trim_out == factory_trim_in)
    else $error("trim not loaded from factory value");
  AST_TRIM_WRITE: assert property (wr_done && avs_address_in == 4'h0 |=> oscillator_trim_out == $past(avs_writedata_in[7:0]))
    else $error("trim write lost");
  AST_TRIM_READ: assert property (rd_done && avs_address_in == 4'h0 |-> avs_readdata_out == {24'h0, oscillator_trim_out})
    else $error("trim read wrong");
  AST_UNMAPPED: assert property (rd_done && avs_address_in == 4'hC |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_GATED: assert property (sys_reset_out |-> !sys_clk_en_out)
    else $error("clock tick during start-up");
  AST_PORT_PASS: assert property (!clock_output_option_in |=> clock_output_pin_out == $past(port_data_in) && clock_output_pin_oe_out == $past(port_oe_in))
    else $error("pin not in port function");
  AST_PIN_OE: assert property (clock_output_option_in && !sys_reset_out |-> clock_output_pin_oe_out)
    else $error("clock pin not driven");
  AST_SLEEP: assert property (power_down_in [*6] |-> !sys_clk_en_out)
    else $error("tick while asleep");
  AST_WAKE_GAP: assert property ($fell(power_down_in) |-> !sys_clk_en_out [*8])
    else $error("wake shorter than start-up count");
endmodule // clk_sel_checker
bind clock_source_select_startup clk_sel_checker chk (.*);

// ---- test/ext_clock_model.sv ----
// External clock source and load on the clock output pin
`timescale 1ns/10ps
module ext_clock_model (
  input  wire        mclk_in,
  input  wire        reset_in,
  input  wire [3:0]  half_in,
  input  wire        pin_in,
  output logic       ext_clk_out,
  output int         pin_edges_out
);
  logic [3:0] half_ff = 4'h2;
  int         cnt = 0;
  initial ext_clk_out = 1'b0;
  initial pin_edges_out = 0;
  always @(posedge mclk_in) begin
    if (reset_in) half_ff <= half_in;
    if (cnt + 1 >= half_ff) begin
      cnt <= 0;
      ext_clk_out <= ~ext_clk_out;
    end else cnt <= cnt + 1;
  end
  always @(pin_in) pin_edges_out = pin_edges_out + 1;
endmodule // ext_clock_model

// ---- test/tb_clock_source_select_startup.sv ----
// Self-checking bench of clock source selection and start-up sequencing
`timescale 1ns/10ps
module tb_clock_source_select_startup;
  localparam int RF = 20, RS = 40, LF = 18, LS = 36;
  logic        mclk_in = 0, reset_in = 1, divide_by_eight_option_in = 0;
  logic        reset_pin_disable_option_in = 0, clock_output_option_in = 0;
  logic        power_down_in = 0, port_data_in = 0, port_oe_in = 0;
  logic        avs_read_in = 0, avs_write_in = 0;
  logic [3:0]  clock_source_select_bits_in = 4'h0, avs_address_in = 4'h0;
  logic [1:0]  startup_time_bits_in = 2'h0;
  logic [7:0]  factory_trim_in = 8'h5A;
  logic [31:0] avs_writedata_in = 32'h0, rdv;
  logic [7:0]  tv[5] = '{8'h7F, 8'h80, 8'h00, 8'h40, 8'h00};
  wire  [31:0] avs_readdata_out;
  wire  [7:0]  oscillator_trim_out;
  wire         avs_waitrequest_out, sys_clk_en_out, sys_reset_out, watchdog_tick_out;
  wire         clock_output_pin_out, clock_output_pin_oe_out, external_clock_in;
  int          pin_edges, error_cnt = 0, checked = 0, cyc, t, p, w, n, lo, hi, tk[5];
  int          trim_q[$];
  int          cs[10] = '{0, 0, 0, 0, 0, 2, 2, 3, 3, 1};
  int          cu[10] = '{0, 1, 2, 3, 0, 0, 1, 0, 2, 0};
  int          cr[10] = '{0, 0, 0, 0, 1, 1, 0, 1, 0, 0};

  clock_source_select_startup #(.RC_FAST_CYC(RF), .RC_SLOW_CYC(RS), .LF_FAST_CYC(LF),
    .LF_SLOW_CYC(LS)) uut (.*);
  ext_clock_model far (.mclk_in(mclk_in), .reset_in(reset_in), .half_in(4'h2),
    .pin_in(clock_output_pin_out), .ext_clk_out(external_clock_in), .pin_edges_out(pin_edges));

  initial forever #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    port_data_in <= 1'($urandom);
    port_oe_in <= 1'($urandom);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int l, input int h);
    chk((v >= l && v <= h) ? l : v, l);
  endtask
  task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk_in);
    avs_read_in <= !w_en;
    avs_write_in <= w_en;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do begin
      @(posedge mclk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    rdv = avs_readdata_out;
    if (k >= 50) chk(32'hDEAD, 32'h0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic boot(input int s, input int u, input int d8, input int r, input int c);
    @(posedge mclk_in);
    clock_source_select_bits_in <= 4'(s);
    startup_time_bits_in <= 2'(u);
    divide_by_eight_option_in <= 1'(d8);
    reset_pin_disable_option_in <= 1'(r);
    clock_output_option_in <= 1'(c);
    factory_trim_in <= 8'($urandom);
    reset_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    cyc = 0;
    while (sys_reset_out !== 1'b0 && cyc < 4000) begin
      @(negedge mclk_in);
      cyc++;
    end
  endtask
  task automatic meas(input int c);
    int p0 = pin_edges;
    t = 0;
    w = 0;
    repeat (c) begin
      @(negedge mclk_in);
      t += (sys_clk_en_out === 1'b1);
      w += (watchdog_tick_out === 1'b1);
    end
    p = pin_edges - p0;
  endtask
  function automatic int dly(input int s, input int u, input int r);
    if (u == 0) return r ? RF : 0;
    if (u == 1) return s == 3 ? LF : RF;
    return s == 3 ? LS : RS;
  endfunction
  task automatic final_report;
    $display("Counts: checked=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk_in);
    error_cnt++;
    final_report();
  end

  initial begin
    void'($urandom(29));
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 10; i++) begin
      boot(cs[i], cu[i], i % 2, cr[i], i % 3 == 0);
      if (cs[i] == 1) begin
        chk(sys_reset_out, 1'b1);
        meas(600);
        chk(t, 0);
        rng(w, 2, 4);
      end else begin
        lo = cs[i] == 3 ? 2500 : cs[i] == 2 ? 30 : 52;
        hi = cs[i] == 3 ? 2950 : 70;
        n = dly(cs[i], cu[i], cr[i]);
        rng(cyc, n + lo, n + hi);
        bus(0, 4'h0, 0);
        chk(rdv, {24'h0, factory_trim_in});
        bus(0, 4'h4, 0);
        chk(rdv[3:0], i % 2 ? 4'h3 : 4'h0);
        bus(0, 4'h8, 0);
        chk(rdv[8:0], {1'(i % 3 == 0), 1'(cr[i]), 1'(i % 2), 2'(cu[i]), 4'(cs[i])});
        meas(320);
        if (cs[i] == 0) rng(t, i % 2 ? 9 : 79, i % 2 ? 11 : 81);
        if (i % 3 == 0) rng(p, t - 1, t + 1);
      end
      if (i == 0) begin
        power_down_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        meas(10);
        chk(t, 0);
        @(posedge mclk_in);
        power_down_in <= 1'b0;
        n = 0;
        while (sys_clk_en_out !== 1'b1 && n < 200) begin
          @(negedge mclk_in);
          n++;
        end
        rng(n, 20, 40);
      end
      if (i == 1) begin
        bus(1, 4'h4, 32'h1);
        bus(0, 4'h4, 0);
        chk(rdv[3:0], 4'h3);
        bus(1, 4'h4, 32'h80);
        bus(1, 4'h4, 32'h0);
        bus(0, 4'h4, 0);
        chk(rdv[3:0], 4'h0);
        meas(320);
        rng(t, 79, 81);
      end
      if (i == 6) begin
        tv[4] = 8'($urandom);
        foreach (tv[j]) begin
          bus(1, 4'h0, {24'h0, tv[j]});
          trim_q.push_back(tv[j]);
          meas(400);
          tk[j] = t;
          bus(0, 4'h0, 0);
          chk(rdv, trim_q.pop_front());
        end
        chk(tk[0] > tk[1], 1);
        chk(tk[3] > tk[2] && tk[0] > tk[3], 1);
        bus(1, 4'hC, 32'hFF);
        bus(0, 4'hC, 0);
        chk(rdv, 0);
        bus(0, 4'h0, 0);
        chk(rdv[7:0], tv[4]);
      end
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule // tb_clock_source_select_startup
